// File: rtl/agc_angle_gain.v
// Axis gain correction, angle computation and result update logic with APB registers.
//
// Overview of operation
// - Angle is computed from two axes; software picks any of the three pairs.
// - Reported angle covers a full turn, all four quadrants.
// - Gain configuration holds a fractional gain between zero and one.
// - Gain code is unsigned; effective gain is code over 1024.
// - Gain choice 00b leaves both axes unscaled and ignores the code.
// - Gain choice 01b scales the first axis before angle computation.
// - Gain choice 10b scales the second axis before angle computation.
// - Raw result registers change only when a conversion finishes; the angle register when the engine finishes.
// - Alert output signals conversion complete to the host.
//
// ****************************************************************
// Register map (byte offsets, one 32-bit word each)
// ****************************************************************
// 0x000 angle_cfg        [1:0] axis pair: 0 X and Y, 1 Y and Z, 2 X and Z.
// 0x004 axis_gain_config [9:0] gain code, [11:10] choice (0 none, 1 first, 2 second).
// 0x008 x_result         Raw X sample of the last conversion, sign-extended.
// 0x00C y_result         Raw Y sample of the last conversion, sign-extended.
// 0x010 z_result         Raw Z sample of the last conversion, sign-extended.
// 0x014 angle            Angle in units of a full turn over 65536.
// 0x018 irq_status       Bit0 conversion done, bit1 angle done; write one to clear.
// 0x01C irq_mask         Same layout as the status word; enables o_irq.
//
// ****************************************************************
// Timing
// ****************************************************************
// Edge c0 samples the conversion pulse and captures the raw results.
// At the same edge c0 status bit0 is set and the alert pin goes low.
// The angle engine runs one step per cycle for sixteen cycles.
// At c17 the angle register and status bit1 are updated together.
// Pulses closer than seventeen cycles refresh the raw results and status bit0 but start no angle computation.
// APB read data is captured in the setup cycle; pready is always high.
// Writes take effect at the access edge; reads show the setup edge's value.
// Unmapped or unaligned addresses answer with pslverr and read zero.
//
// ****************************************************************
// Hazards and limitations
// ****************************************************************
// A status set and a write-one-to-clear in one cycle keep the bit set,
// so an event that lands on the clear is never lost.
// The angle engine does not compensate its own vector growth; it only
// needs the direction, so the growth costs two guard bits and nothing else.
// Gain choice 11b is treated as no gain rather than raising an error.
// A conversion that arrives while the engine is busy still refreshes the
// raw results; the host sees raw data newer than the angle until the
// engine finishes the next conversion that finds it idle.
// The fractional gain never amplifies, so the gained axis cannot overflow.
// Steps beyond the arctangent table add nothing; precision is a few
// counts of a full turn, ample for quadrant and band decisions.
`timescale 1ns/1ns
`include "agc_regs.vh"

module agc_angle_gain #(
    parameter DW = 16                                   // Axis sample width, two's complement.
) (
    input  wire          i_clk,
    input  wire          i_arst_n,
    input  wire          i_psel,
    input  wire          i_penable,
    input  wire          i_pwrite,
    input  wire [11:0]   i_paddr,
    input  wire [31:0]   i_pwdata,
    output reg  [31:0]   o_prdata,
    output wire          o_pready,
    output wire          o_pslverr,
    input  wire          i_conv_done,                   // One-cycle pulse from the converter.
    input  wire [DW-1:0] i_x_data,
    input  wire [DW-1:0] i_y_data,
    input  wire [DW-1:0] i_z_data,
    output wire          o_alert_n,                     // Conversion-complete alert, active low.
    output wire          o_irq
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg  [1:0]    angle_cfg_q;
    reg  [11:0]   gain_cfg_q;
    reg  [DW-1:0] x_res_q;
    reg  [DW-1:0] y_res_q;
    reg  [DW-1:0] z_res_q;
    reg  [15:0]   angle_q;
    reg  [1:0]    irq_stat_q;                           // Bit0 conversion done, bit1 angle done.
    reg  [1:0]    irq_mask_q;
    wire          wr_en = i_psel & i_penable & i_pwrite;
    wire          angle_done;

    // Zero wait states: every access completes in its first access cycle.
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_hit(i_paddr);

    // Decode used by the error answer; the read mux decodes with its own case.
    function addr_hit;
        input [11:0] a;
        begin
            addr_hit = (a[1:0] == 2'h0) && (a <= `AGC_OFS_IRQ_MASK);
        end
    endfunction

    // Sign-extend an axis sample to a common width.
    function [DW:0] sx;
        input [DW-1:0] v;
        begin
            sx = {v[DW-1], v};
        end
    endfunction

    // Writable configuration and sticky status; a new event wins over a clear.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            angle_cfg_q <= `AGC_RST_ANGLE_CFG;
            gain_cfg_q  <= `AGC_RST_GAIN_CFG;
            irq_mask_q  <= {2{`AGC_RST_IRQ_MASK}};
            irq_stat_q  <= 2'h0;
        end else begin
            if (wr_en && i_paddr == `AGC_OFS_ANGLE_CFG)
                angle_cfg_q <= i_pwdata[1:0];
            if (wr_en && i_paddr == `AGC_OFS_GAIN_CFG)
                gain_cfg_q  <= i_pwdata[11:0];
            if (wr_en && i_paddr == `AGC_OFS_IRQ_MASK)
                irq_mask_q  <= i_pwdata[1:0];
            irq_stat_q <= (irq_stat_q
                          & ~((wr_en && i_paddr == `AGC_OFS_IRQ_STAT) ? i_pwdata[1:0] : 2'h0))
                          | {angle_done, i_conv_done};
        end
    end

    // Raw results are captured unscaled, only on conversion completion.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            x_res_q <= {DW{1'b0}};
            y_res_q <= {DW{1'b0}};
            z_res_q <= {DW{1'b0}};
        end else if (i_conv_done) begin
            x_res_q <= i_x_data;
            y_res_q <= i_y_data;
            z_res_q <= i_z_data;
        end
    end

    reg  [31:0]   rd_mux;

    // Read mux; unmapped addresses read zero.
    always @* begin
        rd_mux = 32'h0000_0000;
        case (i_paddr)
            `AGC_OFS_ANGLE_CFG: rd_mux = {30'h0, angle_cfg_q};
            `AGC_OFS_GAIN_CFG:  rd_mux = {20'h0, gain_cfg_q};
            `AGC_OFS_X_RESULT:  rd_mux = {{(32-DW){x_res_q[DW-1]}}, x_res_q};
            `AGC_OFS_Y_RESULT:  rd_mux = {{(32-DW){y_res_q[DW-1]}}, y_res_q};
            `AGC_OFS_Z_RESULT:  rd_mux = {{(32-DW){z_res_q[DW-1]}}, z_res_q};
            `AGC_OFS_ANGLE_RES: rd_mux = {16'h0, angle_q};
            `AGC_OFS_IRQ_STAT:  rd_mux = {30'h0, irq_stat_q};
            `AGC_OFS_IRQ_MASK:  rd_mux = {30'h0, irq_mask_q};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle so the output comes from a flop
    // and the access still needs no wait state; the price is one cycle of age.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            o_prdata <= 32'h0000_0000;
        else if (i_psel && !i_penable)
            o_prdata <= rd_mux;
    end

    assign o_irq = |(irq_stat_q & irq_mask_q);

    // Alert follows the conversion-done status bit so the host can read fresh results.
    assign o_alert_n = ~irq_stat_q[0];

    // ****************************************************************
    // Axis pair selection and gain
    // ****************************************************************
    reg  [DW:0]   pa;
    reg  [DW:0]   pb;
    wire [9:0]    gcode = gain_cfg_q[`AGC_GAIN_VAL_MSB:`AGC_GAIN_VAL_LSB];
    wire [1:0]    gsel  = gain_cfg_q[`AGC_GAIN_SEL_MSB:`AGC_GAIN_SEL_LSB];
    wire [DW+11:0] pa_mul = $signed(pa) * $signed({1'b0, gcode});
    wire [DW+11:0] pb_mul = $signed(pb) * $signed({1'b0, gcode});
    reg  [DW:0]   ga;
    reg  [DW:0]   gb;

    // Pair the axes from the fresh samples; the first of the pair is gained by choice 01b.
    always @* begin
        pa = sx(i_x_data);
        pb = sx(i_y_data);
        case (angle_cfg_q)
            `AGC_PAIR_XY: begin pa = sx(i_x_data); pb = sx(i_y_data); end
            `AGC_PAIR_YZ: begin pa = sx(i_y_data); pb = sx(i_z_data); end
            `AGC_PAIR_XZ: begin pa = sx(i_x_data); pb = sx(i_z_data); end
            default:      begin pa = sx(i_x_data); pb = sx(i_y_data); end
        endcase
    end

    // Multiply by the code and drop ten bits: gain equals code over 1024.
    always @* begin
        ga = pa;
        gb = pb;
        case (gsel)
            `AGC_GAIN_SEL_NONE: begin ga = pa; gb = pb; end
            `AGC_GAIN_SEL_X:    ga = pa_mul[DW+`AGC_GAIN_SHIFT:`AGC_GAIN_SHIFT];
            `AGC_GAIN_SEL_Y:    gb = pb_mul[DW+`AGC_GAIN_SHIFT:`AGC_GAIN_SHIFT];
            default:            begin ga = pa; gb = pb; end
        endcase
    end

    // ****************************************************************
    // Iterative vectoring angle engine
    // ****************************************************************
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    reg           st_q;
    reg  [4:0]    step_q;
    reg  signed [DW+2:0] cx_q;
    reg  signed [DW+2:0] cy_q;
    reg  [15:0]   acc_q;
    reg           done_q;

    // Arctangent of 2^-i in units of a full turn over 65536.
    function [15:0] atan_lut;
        input [4:0] i;
        begin
            case (i)
                5'h00: atan_lut = 16'h2000;
                5'h01: atan_lut = 16'h12E4;
                5'h02: atan_lut = 16'h09FB;
                5'h03: atan_lut = 16'h0511;
                5'h04: atan_lut = 16'h028B;
                5'h05: atan_lut = 16'h0146;
                5'h06: atan_lut = 16'h00A3;
                5'h07: atan_lut = 16'h0051;
                5'h08: atan_lut = 16'h0029;
                5'h09: atan_lut = 16'h0014;
                5'h0A: atan_lut = 16'h000A;
                5'h0B: atan_lut = 16'h0005;
                5'h0C: atan_lut = 16'h0003;
                5'h0D: atan_lut = 16'h0001;
                default: atan_lut = 16'h0000;
            endcase
        end
    endfunction

    wire signed [DW+2:0] sh_x = cx_q >>> step_q;
    wire signed [DW+2:0] sh_y = cy_q >>> step_q;

    // Start on a conversion that finds the engine idle; pre-rotate left half-plane by half a turn for full range.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q   <= ST_IDLE;
            step_q <= 5'h0;
            cx_q   <= {(DW+3){1'b0}};
            cy_q   <= {(DW+3){1'b0}};
            acc_q  <= 16'h0;
            angle_q <= 16'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                ST_IDLE: if (i_conv_done) begin
                    st_q   <= ST_RUN;
                    step_q <= 5'h0;
                    if (ga[DW]) begin
                        cx_q  <= -{{2{ga[DW]}}, ga};
                        cy_q  <= -{{2{gb[DW]}}, gb};
                        acc_q <= 16'h8000;
                    end else begin
                        cx_q  <= {{2{ga[DW]}}, ga};
                        cy_q  <= {{2{gb[DW]}}, gb};
                        acc_q <= 16'h0000;
                    end
                end
                ST_RUN: begin
                    if (cy_q[DW+2]) begin
                        cx_q  <= cx_q - sh_y;
                        cy_q  <= cy_q + sh_x;
                        acc_q <= acc_q - atan_lut(step_q);
                    end else begin
                        cx_q  <= cx_q + sh_y;
                        cy_q  <= cy_q - sh_x;
                        acc_q <= acc_q + atan_lut(step_q);
                    end
                    step_q <= step_q + 5'h1;
                    if (step_q == `AGC_ATAN_STEPS - 5'h1) begin
                        st_q <= ST_IDLE;
                        done_q <= 1'b1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
            if (done_q)
                angle_q <= acc_q;
        end
    end

    assign angle_done = done_q;

endmodule // agc_angle_gain

// File: rtl/agc_regs.vh
// Register offsets, field positions, reset values and constants of the angle gain block.
`ifndef AGC_REGS_VH
`define AGC_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define AGC_OFS_ANGLE_CFG   12'h000
`define AGC_OFS_GAIN_CFG    12'h004
`define AGC_OFS_X_RESULT    12'h008
`define AGC_OFS_Y_RESULT    12'h00C
`define AGC_OFS_Z_RESULT    12'h010
`define AGC_OFS_ANGLE_RES   12'h014
`define AGC_OFS_IRQ_STAT    12'h018
`define AGC_OFS_IRQ_MASK    12'h01C

// ****************************************************************
// Field positions and encodings
// ****************************************************************
`define AGC_GAIN_VAL_LSB    0
`define AGC_GAIN_VAL_MSB    9
`define AGC_GAIN_SEL_LSB    10
`define AGC_GAIN_SEL_MSB    11
`define AGC_GAIN_SEL_NONE   2'h0
`define AGC_GAIN_SEL_X      2'h1
`define AGC_GAIN_SEL_Y      2'h2
`define AGC_GAIN_SHIFT      10
`define AGC_AXIS_X          2'h0
`define AGC_AXIS_Y          2'h1
`define AGC_AXIS_Z          2'h2
`define AGC_PAIR_XY         2'h0
`define AGC_PAIR_YZ         2'h1
`define AGC_PAIR_XZ         2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define AGC_RST_ANGLE_CFG   2'h0
`define AGC_RST_GAIN_CFG    12'h000
`define AGC_RST_IRQ_MASK    1'h0

// ****************************************************************
// Timing counts
// ****************************************************************
`define AGC_ATAN_STEPS      5'h10
`define AGC_PIN_SYNC_STAGES 3

`endif

// File: verification/agc_angle_gain_asserts.sv
// Port checker of the angle gain block.
`timescale 1ns/1ns
module agc_chk #(parameter DW = 16) (
    input logic          i_clk,
    input logic          i_arst_n,
    input logic          i_psel,
    input logic          i_penable,
    input logic          i_pwrite,
    input logic [11:0]   i_paddr,
    input logic [31:0]   i_pwdata,
    input logic [31:0]   o_prdata,
    input logic          o_pready,
    input logic          o_pslverr,
    input logic          i_conv_done,
    input logic [DW-1:0] i_x_data,
    input logic [DW-1:0] i_y_data,
    input logic [DW-1:0] i_z_data,
    input logic          o_alert_n,
    input logic          o_irq
);
    wire           acc  = i_psel && i_penable;
    wire           clr0 = acc && i_pwrite && i_paddr == 12'h018 && i_pwdata[0];
    logic [DW-1:0] x_q;
    logic [11:0]   gain_q;
    // Shadows of the last X sample and gain word; reads are judged against them.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            x_q    <= '0;
            gain_q <= '0;
        end else begin
            x_q    <= i_conv_done ? i_x_data : x_q;
            gain_q <= (acc && i_pwrite && i_paddr == 12'h004) ? i_pwdata[11:0] : gain_q;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_rd(a); acc && !i_pwrite && i_paddr == a; endsequence
    sequence s_mask_off; acc && i_pwrite && i_paddr == 12'h01C && i_pwdata[1:0] == 2'h0;
    endsequence
    a_alert_after_done: assert property (i_conv_done |=> !o_alert_n)
        else $error("alert missing after conversion");
    a_alert_sticky: assert property (!o_alert_n && !clr0 |=> !o_alert_n)
        else $error("alert dropped without clear");
    a_alert_cause: assert property ($fell(o_alert_n) |-> $past(i_conv_done))
        else $error("alert without conversion");
    a_xres_read: assert property (s_rd(12'h008) |->
        o_prdata == {{(32-DW){$past(x_q[DW-1])}}, $past(x_q)}) else $error("x result differs");
    a_gain_readback: assert property (s_rd(12'h004) |->
        o_prdata == {20'h0, $past(gain_q)}) else $error("gain word differs");
    a_slverr_map: assert property (acc |-> o_pready &&
        o_pslverr == (i_paddr > 12'h01C || i_paddr[1:0] != 2'h0)) else $error("bad error flag");
    a_irq_masked: assert property (s_mask_off |=> !o_irq) else $error("irq while masked");
    a_alert_idle: assert property (!i_conv_done && o_alert_n |=> o_alert_n)
        else $error("alert without cause");
endmodule // agc_chk
bind agc_angle_gain agc_chk #(.DW(DW)) agc_chk_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_conv_done(i_conv_done), .i_x_data(i_x_data), .i_y_data(i_y_data),
    .i_z_data(i_z_data), .o_alert_n(o_alert_n), .o_irq(o_irq));

// File: verification/agc_conv_model.sv
// Converter model that presents axis samples with a one-cycle completion pulse.
`timescale 1ns/1ns
module agc_conv_model (
    input  logic        i_clk,
    output logic        o_conv_done,
    output logic [15:0] o_x_data,
    output logic [15:0] o_y_data,
    output logic [15:0] o_z_data
);
    initial {o_conv_done, o_x_data, o_y_data, o_z_data} = '0;
    // Off the pulse the lines carry inverted samples, so a stray capture shows.
    task automatic convert(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(posedge i_clk);
        {o_conv_done, o_x_data, o_y_data, o_z_data} <= {1'h1, x, y, z};
        @(posedge i_clk);
        {o_conv_done, o_x_data, o_y_data, o_z_data} <= {1'h0, ~x, ~y, ~z};
    endtask
endmodule // agc_conv_model

// File: verification/agc_angle_gain_bench.sv
// Self-checking bench of the angle gain block.
`timescale 1ns/1ns
module agc_angle_gain_bench;
    logic        i_clk = 1'h0, i_arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, conv_done, alert_n, irq, e;
    logic [15:0] xd, yd, zd, f, s, t;
    int          miscompares = 0, total_checks = 0;
    always #25 i_clk = ~i_clk;
    agc_conv_model agc_conv_model_inst (.i_clk(i_clk), .o_conv_done(conv_done),
        .o_x_data(xd), .o_y_data(yd), .o_z_data(zd));
    agc_angle_gain agc_angle_gain_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_conv_done(conv_done),
        .i_x_data(xd), .i_y_data(yd), .i_z_data(zd), .o_alert_n(alert_n), .o_irq(irq));
    task automatic conclude();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge i_clk);
        penable <= 1'h1;
        @(posedge i_clk);
        while (pready !== 1'h1)
            @(posedge i_clk);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(q, exp);
    endtask
    // Reads follow completion by a margin, as a careful host would time them.
    task automatic conv(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        agc_conv_model_inst.convert(x, y, z);
        repeat (20) @(posedge i_clk);
    endtask
    function automatic logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction
    // Angle class: near 45 degrees, well above it, or well below it.
    function automatic logic [31:0] band(input logic [15:0] a);
        return a > 16'h2500 ? 32'h1 : (a < 16'h1B00 ? 32'h2 : 32'h0);
    endfunction
    function automatic logic [11:0] gain_code(input int ax, input int ay);
        return 12'(ay * 1024 / ax);
    endfunction
    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        conclude();
    end
    initial begin
        void'($urandom(59161));
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'h1;
        for (int a = 0; a < 32; a += 4) rd(a[11:0], 32'h0);
        chk({30'h0, alert_n, irq}, 32'h2);
        apb(1'h0, 12'h020, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'h0, 12'h006, 32'h0);
        chk({31'h0, e}, 32'h1);
        t = 16'($urandom);
        apb(1'h1, 12'h004, {20'h0, t[11:0]});
        rd(12'h004, {20'h0, t[11:0]});
        for (int i = 0; i < 6; i++) begin
            {f, s, t} = 48'({$urandom, $urandom});
            conv(f, s, t);
            rd(12'h008, sx(f));
            rd(12'h00C, sx(s));
            rd(12'h010, sx(t));
            chk({31'h0, alert_n}, 32'h0);
            rd(12'h018, 32'h3);
            apb(1'h1, 12'h018, 32'h3);
            #5 chk({31'h0, alert_n}, 32'h1);
        end
        apb(1'h1, 12'h004, 32'h0);
        for (int p = 0; p < 3; p++) begin
            apb(1'h1, 12'h000, p);
            for (int k = 0; k < 4; k++) begin
                f = (k == 0 || k == 3) ? 16'h1F40 : 16'hE0C0;
                s = (k < 2) ? 16'h1F40 : 16'hE0C0;
                conv(p == 1 ? 16'h0 : f, p == 0 ? s : (p == 1 ? f : 16'h0), p == 0 ? 16'h0 : s);
                apb(1'h0, 12'h014, 32'h0);
                chk({30'h0, q[15:14]}, k);
            end
        end
        apb(1'h1, 12'h000, 32'h0);
        for (int g = 0; g < 4; g++) begin
            t = {4'h0, gain_code(60000, 30000)};
            apb(1'h1, 12'h004, {20'h0, g[1:0], t[9:0]});
            t = 16'($urandom);
            conv(16'h1F40, 16'h1F40, t);
            apb(1'h0, 12'h014, 32'h0);
            chk(band(q[15:0]), g == 1 ? 1 : (g == 2 ? 2 : 0));
        end
        apb(1'h1, 12'h01C, 32'h3);
        #5 chk(irq, 32'h1);
        apb(1'h1, 12'h01C, 32'h0);
        #5 chk(irq, 32'h0);
        apb(1'h1, 12'h01C, 32'h2);
        apb(1'h1, 12'h018, 32'h2);
        #5 chk(irq, 32'h0);
        rd(12'h018, 32'h1);
        conclude();
    end
endmodule // agc_angle_gain_bench
